/* rtl/tap_pkg.sv */
// package for the translation buffer array access port: address map, field layouts, sizes
// assumes a classic wishbone slave with 32-bit data and byte addresses
package tap_pkg;
   // buffer geometry, unified and instruction
   localparam int          TAP_UNI_ENTRIES = 64;              // six-bit index
   localparam int          TAP_INS_ENTRIES = 4;               // two-bit index
   // region codes compared against the upper address bits
   localparam logic [7:0]  TAP_UAA_CODE    = 8'h_F6;          // unified address array, bits 31:24
   localparam logic [8:0]  TAP_UDA1_CODE   = 9'h_1EE;         // 0xF70 >> 3, bits 31:23
   localparam logic [8:0]  TAP_UDA2_CODE   = 9'h_1EF;         // 0xF78 >> 3, bits 31:23
   localparam logic [8:0]  TAP_IDA2_CODE   = 9'h_1E7;         // 0xF38 >> 3, bits 31:23
   // address field positions
   localparam int          TAP_UIDX_LSB    = 8;               // unified index 13:8
   localparam int          TAP_IIDX_LSB    = 8;               // instruction index 9:8
   localparam int          TAP_ASSOC_BIT   = 7;               // associate-select flag
   // address array data word
   localparam int          TAP_VPN_LSB     = 10;              // page number 31:10
   localparam int          TAP_DIRTY_BIT   = 9;
   localparam int          TAP_VALID_BIT   = 8;
   localparam int          TAP_SPACE_LSB   = 0;               // space identifier 7:0
   // data array 1 word
   localparam int          TAP_PPN_LSB     = 10;              // physical page 28:10
   localparam int          TAP_SZ_HI_BIT   = 7;
   localparam int          TAP_PR_LSB      = 5;               // protection 6:5
   localparam int          TAP_SZ_LO_BIT   = 4;
   localparam int          TAP_CACHE_BIT   = 3;
   localparam int          TAP_D1_DIRTY    = 2;
   localparam int          TAP_SHARED_BIT  = 1;
   localparam int          TAP_WT_BIT      = 0;
   // data array 2 word
   localparam int          TAP_TC_BIT      = 3;
   localparam int          TAP_SA_LSB      = 0;               // space attribute 2:0
   // read value when an unmapped or unsupported region is read
   localparam logic [31:0] TAP_ZERO_WORD   = 32'h_0000_0000;

   // one unified entry
   typedef struct packed {
      logic [21:0] virtual_page_number;
      logic        dirty;
      logic        valid;
      logic [7:0]  space_identifier;
      logic [18:0] physical_page_number;
      logic [1:0]  page_size;
      logic [1:0]  protection_code;
      logic        cacheable;
      logic        shared_flag;
      logic        write_through_flag;
      logic        timing_control_flag;
      logic [2:0]  space_attribute;
   } tap_uni_entry_t;

   // one instruction entry (only fields the port touches)
   typedef struct packed {
      logic [21:0] virtual_page_number;
      logic        valid;
      logic [7:0]  space_identifier;
      logic        timing_control_flag;
      logic [2:0]  space_attribute;
   } tap_ins_entry_t;

   // wishbone request bundle
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  sel;
      logic [31:0] adr;
      logic [31:0] dat;
   } tap_wb_req_t;

   // decoded target region
   typedef enum logic [2:0] {
      TAP_RGN_NONE = 3'b000,
      TAP_RGN_UAA  = 3'b001,
      TAP_RGN_UDA1 = 3'b010,
      TAP_RGN_UDA2 = 3'b011,
      TAP_RGN_IDA2 = 3'b100
   } tap_region_t;

   // slave phase
   typedef enum logic [0:0] {
      TAP_ST_IDLE = 1'b0,
      TAP_ST_ACK  = 1'b1
   } tap_state_t;
endpackage

/* rtl/tap_array_port.sv */
// memory-mapped access port to the unified and instruction translation buffer arrays
// assumes a classic wishbone master (the core load/store path) issuing one access at a time; partial widths get an error answer
`timescale 1ns/100ps

module tap_array_port
   import tap_pkg::*;
(
   input  wire logic        clk_i,            // core clock, 250 MHz
   input  wire logic        rst_i,            // synchronous reset, active high
   input  wire logic        cyc_i,            // wishbone cycle
   input  wire logic        stb_i,            // wishbone strobe
   input  wire logic        we_i,             // write enable
   input  wire logic [3:0]  sel_i,            // byte selects
   input  wire logic [31:0] adr_i,            // byte address
   input  wire logic [31:0] dat_i,            // write data
   input  wire logic [7:0]  cur_space_id_i,   // space identifier of page_entry_high_reg
   output logic      [31:0] dat_o,            // read data
   output logic             ack_o,            // transfer acknowledge
   output logic             err_o,            // error acknowledge
   output logic             multi_hit_o       // one-cycle data multiple-hit exception
);
   import tap_pkg::*;

   // all control state in one struct
   typedef struct packed {
      tap_state_t  phase;
      logic [31:0] rdata;
      logic        ack;
      logic        err;
      logic        mhit;
   } tap_ctl_t;

   tap_uni_entry_t uni_r [TAP_UNI_ENTRIES];  // unified buffer, one entry per index
   tap_ins_entry_t ins_r [TAP_INS_ENTRIES];  // instruction buffer
   tap_ctl_t       ctl_r;                    // registered control
   tap_ctl_t       ctl_nxt;                  // next control
   tap_wb_req_t    req;                      // bundled request

   // decode only the region code; low bits and between-field bits are don't-care
   function automatic tap_region_t tap_decode(input logic [31:0] a);
      if (a[31:24] == TAP_UAA_CODE)                  tap_decode = TAP_RGN_UAA;
      else if (a[31:23] == TAP_UDA1_CODE)            tap_decode = TAP_RGN_UDA1;
      else if (a[31:23] == TAP_UDA2_CODE)            tap_decode = TAP_RGN_UDA2;
      else if (a[31:23] == TAP_IDA2_CODE)            tap_decode = TAP_RGN_IDA2;
      else                                           tap_decode = TAP_RGN_NONE;
   endfunction

   // unified index from address
   function automatic logic [5:0] tap_uidx(input logic [31:0] a);
      tap_uidx = a[TAP_UIDX_LSB +: 6];
   endfunction

   // instruction index from address
   function automatic logic [1:0] tap_iidx(input logic [31:0] a);
      tap_iidx = a[TAP_IIDX_LSB +: 2];
   endfunction

   assign req = '{cyc: cyc_i, stb: stb_i, we: we_i, sel: sel_i, adr: adr_i, dat: dat_i};

   // request is new only in idle, so each access acts exactly once
   logic        go;          // accepted request this cycle
   logic        lword;       // full longword selected
   tap_region_t rgn;         // decoded region
   logic [5:0]  uix;         // unified index
   logic [1:0]  iix;         // instruction index
   logic        assoc_wr;    // associative address array write
   logic [TAP_UNI_ENTRIES-1:0] uhit;  // unified match vector
   logic [TAP_INS_ENTRIES-1:0] ihit;  // instruction match vector
   logic [6:0]  uhit_cnt;    // number of unified matches
   logic [5:0]  uhit_idx;    // index of a unified match

   assign go       = req.cyc && req.stb && (ctl_r.phase == TAP_ST_IDLE);
   assign lword    = (req.sel == 4'h_F);
   assign rgn      = tap_decode(req.adr);
   assign uix      = tap_uidx(req.adr);
   assign iix      = tap_iidx(req.adr);
   assign assoc_wr = go && req.we && lword && (rgn == TAP_RGN_UAA) && req.adr[TAP_ASSOC_BIT];

   // associative compare over both buffers; page number plus current space id
   always_comb begin
      uhit_cnt = 7'h_00;
      uhit_idx = 6'h_00;
      for (int i = 0; i < TAP_UNI_ENTRIES; i++) begin
         // normal rules: valid entry, page equal, space equal unless shared
         uhit[i] = uni_r[i].valid
                   && (uni_r[i].virtual_page_number == req.dat[31:TAP_VPN_LSB])
                   && (uni_r[i].shared_flag || (uni_r[i].space_identifier == cur_space_id_i));
         if (uhit[i]) begin
            uhit_cnt = uhit_cnt + 7'h_01;
            uhit_idx = 6'(i);
         end
      end
      for (int j = 0; j < TAP_INS_ENTRIES; j++) begin
         ihit[j] = ins_r[j].valid
                   && (ins_r[j].virtual_page_number == req.dat[31:TAP_VPN_LSB])
                   && (ins_r[j].space_identifier == cur_space_id_i);
      end
   end

   // control next state: one-cycle ack after acceptance
   always_comb begin
      ctl_nxt      = ctl_r;
      ctl_nxt.ack  = 1'b0;
      ctl_nxt.err  = 1'b0;
      ctl_nxt.mhit = 1'b0;
      case (ctl_r.phase)
         TAP_ST_IDLE: begin
            if (go) begin
               ctl_nxt.phase = TAP_ST_ACK;
               // partial width or unmapped: error answer, no state change
               if (!lword || rgn == TAP_RGN_NONE) begin
                  ctl_nxt.err   = 1'b1;
                  ctl_nxt.rdata = TAP_ZERO_WORD;
               end else begin
                  ctl_nxt.ack   = 1'b1;
                  ctl_nxt.rdata = TAP_ZERO_WORD;                              // reserved bits read zero
                  case (rgn)
                     TAP_RGN_UAA: begin
                        // indexed read, flag ignored
                        ctl_nxt.rdata[31:TAP_VPN_LSB]  = uni_r[uix].virtual_page_number;
                        ctl_nxt.rdata[TAP_DIRTY_BIT]   = uni_r[uix].dirty;
                        ctl_nxt.rdata[TAP_VALID_BIT]   = uni_r[uix].valid;
                        ctl_nxt.rdata[TAP_SPACE_LSB +: 8] = uni_r[uix].space_identifier;
                     end
                     TAP_RGN_UDA1: begin
                        // physical-side fields
                        ctl_nxt.rdata[28:TAP_PPN_LSB]    = uni_r[uix].physical_page_number;
                        ctl_nxt.rdata[TAP_VALID_BIT]     = uni_r[uix].valid;
                        ctl_nxt.rdata[TAP_SZ_HI_BIT]     = uni_r[uix].page_size[1];
                        ctl_nxt.rdata[TAP_PR_LSB +: 2]   = uni_r[uix].protection_code;
                        ctl_nxt.rdata[TAP_SZ_LO_BIT]     = uni_r[uix].page_size[0];
                        ctl_nxt.rdata[TAP_CACHE_BIT]     = uni_r[uix].cacheable;
                        ctl_nxt.rdata[TAP_D1_DIRTY]      = uni_r[uix].dirty;
                        ctl_nxt.rdata[TAP_SHARED_BIT]    = uni_r[uix].shared_flag;
                        ctl_nxt.rdata[TAP_WT_BIT]        = uni_r[uix].write_through_flag;
                     end
                     TAP_RGN_UDA2: begin
                        ctl_nxt.rdata[TAP_TC_BIT]        = uni_r[uix].timing_control_flag;
                        ctl_nxt.rdata[TAP_SA_LSB +: 3]   = uni_r[uix].space_attribute;
                     end
                     TAP_RGN_IDA2: begin
                        ctl_nxt.rdata[TAP_TC_BIT]        = ins_r[iix].timing_control_flag;
                        ctl_nxt.rdata[TAP_SA_LSB +: 3]   = ins_r[iix].space_attribute;
                     end
                     default: ctl_nxt.rdata = TAP_ZERO_WORD;
                  endcase
                  // more than one unified match: exception, no unified update
                  if (assoc_wr && uhit_cnt > 7'h_01)
                     ctl_nxt.mhit = 1'b1;
               end
            end
         end
         TAP_ST_ACK: begin
            // ack lasts one cycle; master drops the strobe before the next access
            ctl_nxt.phase = TAP_ST_IDLE;
         end
         default: ctl_nxt.phase = TAP_ST_IDLE;
      endcase
   end

   // control register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctl_r <= '{phase: TAP_ST_IDLE, rdata: TAP_ZERO_WORD, ack: 1'b0, err: 1'b0, mhit: 1'b0};
      end else begin
         ctl_r <= ctl_nxt;
      end
   end

   // array writes; the arrays carry no reset, as buffer contents are undefined at power-up
   // except valid bits and unified dirty bits, cleared so no stale entry hits
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < TAP_UNI_ENTRIES; i++) begin
            uni_r[i].valid <= 1'b0;
            uni_r[i].dirty <= 1'b0;
         end
         for (int j = 0; j < TAP_INS_ENTRIES; j++) begin
            ins_r[j].valid <= 1'b0;
         end
      end else if (go && req.we && lword) begin
         case (rgn)
            TAP_RGN_UAA: begin
               if (!req.adr[TAP_ASSOC_BIT]) begin
                  // direct indexed write of all four fields
                  uni_r[uix].virtual_page_number <= req.dat[31:TAP_VPN_LSB];
                  uni_r[uix].dirty               <= req.dat[TAP_DIRTY_BIT];
                  uni_r[uix].valid               <= req.dat[TAP_VALID_BIT];
                  uni_r[uix].space_identifier    <= req.dat[TAP_SPACE_LSB +: 8];
               end else begin
                  // exactly one match: dirty and valid only; zero: untouched
                  if (uhit_cnt == 7'h_01) begin
                     uni_r[uhit_idx].dirty <= req.dat[TAP_DIRTY_BIT];
                     uni_r[uhit_idx].valid <= req.dat[TAP_VALID_BIT];
                  end
                  // instruction side updated regardless of unified result
                  for (int j = 0; j < TAP_INS_ENTRIES; j++) begin
                     if (ihit[j]) begin
                        ins_r[j].valid <= req.dat[TAP_VALID_BIT];
                        if (uhit_cnt == 7'h_01) begin
                           // both hit: copy unified information across
                           ins_r[j].timing_control_flag <= uni_r[uhit_idx].timing_control_flag;
                           ins_r[j].space_attribute     <= uni_r[uhit_idx].space_attribute;
                        end
                     end
                  end
               end
            end
            TAP_RGN_UDA1: begin
               // replace all eight fields
               uni_r[uix].physical_page_number <= req.dat[28:TAP_PPN_LSB];
               uni_r[uix].valid                <= req.dat[TAP_VALID_BIT];
               uni_r[uix].page_size            <= {req.dat[TAP_SZ_HI_BIT], req.dat[TAP_SZ_LO_BIT]};
               uni_r[uix].protection_code      <= req.dat[TAP_PR_LSB +: 2];
               uni_r[uix].cacheable            <= req.dat[TAP_CACHE_BIT];
               uni_r[uix].dirty                <= req.dat[TAP_D1_DIRTY];
               uni_r[uix].shared_flag          <= req.dat[TAP_SHARED_BIT];
               uni_r[uix].write_through_flag   <= req.dat[TAP_WT_BIT];
            end
            TAP_RGN_UDA2: begin
               uni_r[uix].timing_control_flag  <= req.dat[TAP_TC_BIT];
               uni_r[uix].space_attribute      <= req.dat[TAP_SA_LSB +: 3];
            end
            TAP_RGN_IDA2: begin
               ins_r[iix].timing_control_flag  <= req.dat[TAP_TC_BIT];
               ins_r[iix].space_attribute      <= req.dat[TAP_SA_LSB +: 3];
            end
            default: ;
         endcase
      end
   end

   // outputs straight from registers
   assign dat_o       = ctl_r.rdata;
   assign ack_o       = ctl_r.ack;
   assign err_o       = ctl_r.err;
   assign multi_hit_o = ctl_r.mhit;
endmodule

/* sim/tap_array_port_properties.sv */
// assertions on the array port: answer timing, region decode, exception pulse
// assumes one clock and the synchronous active-high reset
`timescale 1ns/100ps
module tap_array_port_checker
   import tap_pkg::*;
(
   input wire logic        clk_i,          // core clock
   input wire logic        rst_i,          // reset
   input wire logic        cyc_i,          // cycle
   input wire logic        stb_i,          // strobe
   input wire logic        we_i,           // write
   input wire logic [3:0]  sel_i,          // byte selects
   input wire logic [31:0] adr_i,          // address
   input wire logic [31:0] dat_i,          // write data
   input wire logic [7:0]  cur_space_id_i, // current space
   input wire logic [31:0] dat_o,          // read data
   input wire logic        ack_o,          // acknowledge
   input wire logic        err_o,          // error
   input wire logic        multi_hit_o     // multi-hit pulse
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // request taken now; stb in the answer cycle is ignored, so it is left out
   wire logic take     = cyc_i && stb_i && !ack_o && !err_o;
   wire logic lw       = take && sel_i == 4'h_F;
   wire logic assoc_wr = we_i && adr_i[31:24] == TAP_UAA_CODE && adr_i[TAP_ASSOC_BIT];
   property p_answer; take |=> ack_o != err_o; endproperty
   a_answer: assert property (p_answer) else $error("request not answered once");
   property p_pulse; ack_o || err_o |=> !ack_o && !err_o; endproperty
   a_pulse: assert property (p_pulse) else $error("answer longer than one cycle");
   property p_uaa; lw && adr_i[31:24] == TAP_UAA_CODE |=> ack_o; endproperty
   a_uaa: assert property (p_uaa) else $error("address array not decoded");
   property p_uda1; lw && adr_i[31:23] == TAP_UDA1_CODE |=> ack_o; endproperty
   a_uda1: assert property (p_uda1) else $error("data array 1 not decoded");
   property p_uda2; lw && adr_i[31:23] == TAP_UDA2_CODE |=> ack_o; endproperty
   a_uda2: assert property (p_uda2) else $error("data array 2 not decoded");
   property p_ida2; lw && adr_i[31:23] == TAP_IDA2_CODE |=> ack_o; endproperty
   a_ida2: assert property (p_ida2) else $error("instr data array 2 not decoded");
   property p_sel; take && sel_i != 4'h_F |=> err_o && dat_o == TAP_ZERO_WORD; endproperty
   a_sel: assert property (p_sel) else $error("partial access not refused");
   property p_nomulti; take && !assoc_wr |=> !multi_hit_o; endproperty
   a_nomulti: assert property (p_nomulti) else $error("multi hit without associative write");
   property p_multi; multi_hit_o |-> ack_o && $past(assoc_wr); endproperty
   a_multi: assert property (p_multi) else $error("multi hit off its answer");
   property p_rsvd; lw && !we_i && adr_i[31:23] == TAP_UDA2_CODE |=> dat_o[31:4] == 28'h_000_0000; endproperty
   a_rsvd: assert property (p_rsvd) else $error("data array 2 upper bits set");
endmodule

bind tap_array_port tap_array_port_checker chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
   .we_i(we_i), .sel_i(sel_i), .adr_i(adr_i), .dat_i(dat_i), .cur_space_id_i(cur_space_id_i), .dat_o(dat_o),
   .ack_o(ack_o), .err_o(err_o), .multi_hit_o(multi_hit_o));

/* sim/tap_core_model.sv */
// core load/store path model: classic wishbone master, one access at a time with the byte selects it is given
// assumes the bench calls xfer right after a rising clock edge
`timescale 1ns/100ps
module tap_core_model
   import tap_pkg::*;
(
   input  wire logic           clk_i, // core clock
   input  wire logic [31:0]    dat_i, // read data
   input  wire logic           ack_i, // acknowledge
   input  wire logic           err_i, // error acknowledge
   output tap_pkg::tap_wb_req_t req_o  // request bundle
);
   initial req_o = '0; // bus idle at time zero
   // full address and data word held until the answer edge
   task automatic xfer(input logic w, input logic [3:0] s, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      req_o <= '{cyc: 1'h_1, stb: 1'h_1, we: w, sel: s, adr: a, dat: d};
      @(posedge clk_i);
      while (!(ack_i || err_i)) @(posedge clk_i); // no latency assumed
      q = dat_i;
      e = err_i;
      // released lines carry inverted leftovers, never the old request
      req_o <= '{cyc: 1'h_0, stb: 1'h_0, we: ~w, sel: ~s, adr: ~a, dat: ~d};
      @(posedge clk_i);
   endtask
endmodule

/* sim/tap_array_port_bench.sv */
// self-checking bench for the array port: reset, fill, read-back, random mix
// assumes the core model drives the bus and the checker is bound to the port
`timescale 1ns/100ps
`define CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin failures++; \
   $display("wrong value %s expected %h seen %h", what, exp, got); end end
module tap_array_port_bench;
   import tap_pkg::*;
   logic           clk_i, rst_i;           // clock, reset
   logic [7:0]     cur_space_id_i;         // current space identifier
   logic [31:0]    dat_o;                  // read data
   logic           ack_o, err_o;           // answers
   logic           multi_hit_o, mh_seen;   // exception pulse and its latch
   tap_wb_req_t    req;                    // request from the core model
   tap_uni_entry_t um [TAP_UNI_ENTRIES];   // expected unified contents
   logic [3:0]     im [TAP_INS_ENTRIES];   // expected instruction timing and attribute
   int             failures, checks;       // counters

   tap_array_port uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(req.cyc), .stb_i(req.stb), .we_i(req.we),
      .sel_i(req.sel), .adr_i(req.adr), .dat_i(req.dat), .cur_space_id_i(cur_space_id_i), .dat_o(dat_o),
      .ack_o(ack_o), .err_o(err_o), .multi_hit_o(multi_hit_o));
   tap_core_model core (.clk_i(clk_i), .dat_i(dat_o), .ack_i(ack_o), .err_i(err_o), .req_o(req));

   initial begin
      clk_i = 1'h_0;
      forever #2 clk_i = ~clk_i;
   end
   // the pulse lives one cycle, so latch it at the answer edge
   always @(posedge clk_i) begin
      if (ack_o || err_o) mh_seen <= multi_hit_o;
   end

   // expected read word, reserved bits zero
   function automatic logic [31:0] exp_read(input int k, input int i);
      tap_uni_entry_t u;
      u = um[i];
      case (k)
         0: return {u.virtual_page_number, u.dirty, u.valid, u.space_identifier};
         1: return {3'h_0, u.physical_page_number, 1'h_0, u.valid, u.page_size[1], u.protection_code,
                    u.page_size[0], u.cacheable, u.dirty, u.shared_flag, u.write_through_flag};
         2: return {28'h_000_0000, u.timing_control_flag, u.space_attribute};
         default: return {28'h_000_0000, im[i]};
      endcase
   endfunction
   // count unified hits of a page under the current space; shared entries ignore space
   function automatic int hits(input logic [21:0] p, output int at);
      int n;
      n = 0;
      at = 0;
      for (int j = 0; j < TAP_UNI_ENTRIES; j++) begin
         if (um[j].valid && um[j].virtual_page_number == p &&
             (um[j].shared_flag || um[j].space_identifier == cur_space_id_i)) begin
            n++;
            at = j;
         end
      end
      return n;
   endfunction
   // one access: k selects the region (4 = unserved), filler address bits random
   task automatic acc(input int k, input logic w, input int i, input logic asc, input logic [31:0] d,
                      input logic [3:0] s);
      logic [31:0] a, r, q;
      logic        e, xe;
      int          n, at;
      r = $urandom;
      case (k)
         0: a = {TAP_UAA_CODE, r[23:14], i[5:0], asc, r[6:2], 2'h_0};
         1: a = {TAP_UDA1_CODE, r[22:14], i[5:0], r[7:2], 2'h_0};
         2: a = {TAP_UDA2_CODE, r[22:14], i[5:0], r[7:2], 2'h_0};
         3: a = {TAP_IDA2_CODE, r[22:10], i[1:0], r[7:2], 2'h_0};
         default: a = {8'h_F2, r[23:0]};
      endcase
      xe = (k > 3) || (s != 4'h_F);
      n = hits(d[31:10], at);
      core.xfer(w, s, a, d, q, e);
      `CHK("error answer", xe, e)
      if (!xe && !w) `CHK("read data", exp_read(k, i), q)
      if (!xe && w && k == 0 && asc) `CHK("multi hit", n > 1, mh_seen)
      if (!xe && w) begin
         case (k)
            0: begin
               if (!asc) {um[i].virtual_page_number, um[i].dirty, um[i].valid, um[i].space_identifier} = d;
               else if (n == 1) {um[at].dirty, um[at].valid} = d[9:8];
            end
            1: {um[i].physical_page_number, um[i].valid, um[i].page_size[1], um[i].protection_code, um[i].page_size[0],
                um[i].cacheable, um[i].dirty, um[i].shared_flag, um[i].write_through_flag} = {d[28:10], d[8:0]};
            2: {um[i].timing_control_flag, um[i].space_attribute} = d[3:0];
            default: im[i] = d[3:0];
         endcase
      end
   endtask

   task automatic final_report();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // watchdog: the run needs well under a quarter of this span
   initial begin
      #200_000;
      failures++;
      final_report();
   end

   initial begin
      logic [31:0] r, q;
      logic        e;
      int          j;
      rst_i = 1'h_1;
      cur_space_id_i = 8'h_00;
      failures = 0;
      checks = 0;
      void'($urandom(13));
      repeat (3) @(posedge clk_i);
      rst_i <= 1'h_0;
      @(posedge clk_i);
      core.xfer(1'h_0, 4'h_F, {TAP_UAA_CODE, 24'h_00_2500}, 32'h_0000_0000, q, e);
      `CHK("reset flags", 2'h_0, q[9:8])
      $display("reset test done");
      // fill every entry with a unique page, reserved bits zero
      for (int i = 0; i < TAP_UNI_ENTRIES; i++) begin
         r = $urandom;
         acc(1, 1'h_1, i, 1'h_0, r & 32'h_1FFF_FDFF, 4'h_F);
         acc(2, 1'h_1, i, 1'h_0, r & 32'h_0000_000F, 4'h_F);
         acc(0, 1'h_1, i, 1'h_0, {r[31:16], i[5:0], r[9:0]}, 4'h_F);
         if (i < TAP_INS_ENTRIES) acc(3, 1'h_1, i, 1'h_0, {28'h_000_0000, r[7:4]}, 4'h_F);
      end
      for (int i = 0; i < TAP_UNI_ENTRIES * 4; i++) begin
         if (i % 4 < 3 || i / 4 < TAP_INS_ENTRIES) acc(i % 4, 1'h_0, i / 4, i[2], 32'h_0, 4'h_F);
      end
      $display("fill test done");
      // mid-run reset: valid and dirty drop in every entry, the other fields survive
      rst_i <= 1'h_1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'h_0;
      @(posedge clk_i);
      for (int i = 0; i < TAP_UNI_ENTRIES; i++) begin
         {um[i].dirty, um[i].valid} = 2'h_0;
         acc(i % 2, 1'h_0, i, i[1], 32'h_0, 4'h_F);
      end
      $display("second reset test done");
      // random mix; reused pages and direct writes provoke single and multiple hits
      for (int t = 0; t < 1500; t++) begin
         r = $urandom;
         j = $urandom_range(63);
         case (r[2:0])
            0, 1: acc(0, 1'h_1, j, r[3], {um[r[13:8]].virtual_page_number, r[23:14]}, 4'h_F);
            2: acc(0, 1'h_0, j, r[3], 32'h_0, 4'h_F);
            3: acc(1, r[3], j, 1'h_0, r & 32'h_1FFF_FDFF, 4'h_F);
            4: acc(2, r[3], j, 1'h_0, r & 32'h_0000_000F, 4'h_F);
            5: acc(3, r[3], j % 4, 1'h_0, r & 32'h_0000_000F, 4'h_F);
            6: acc(r[3] ? 4 : 0, 1'h_1, j, 1'h_0, r & 32'h_FFFF_FDFF, r[3] ? 4'h_F : {r[7:5], 1'h_0});
            default: begin
               cur_space_id_i <= um[j].space_identifier;
               @(posedge clk_i);
            end
         endcase
      end
      $display("random test done");
      final_report();
   end
endmodule
